// file: core/dpc_ctl.sv
// Controller end: plays host and MPU toward the register bank.
// Assumes an APB master on sys_clk; software launches one transfer at a time.
`timescale 1ns/1ps
`default_nettype none

module dpc_ctl
	import dpc_pkg::*;
(
	input  wire logic        sys_clk,  // System clock.
	input  wire logic        rst,      // Synchronous reset.
	input  wire logic        psel,     // APB select.
	input  wire logic        penable,  // APB enable.
	input  wire logic        pwrite,   // APB direction.
	input  wire logic [7:0]  paddr,    // APB byte address.
	input  wire logic [31:0] pwdata,   // APB write data.
	output logic      [31:0] prdata,   // APB read data.
	output logic             pready,   // APB ready.
	output logic             pslverr,  // APB error, unmapped address.
	dpc_if.ctl               port      // Bank ports.
);

	// ---------------------------------------------------------------
	// State and registers.
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		DPC_IDLE = 2'b01, // No transfer.
		DPC_WAIT = 2'b10  // Request out, waiting for the answer.
	} dpc_state_t;

	dpc_state_t  state;       // Transfer state.
	logic        cmd_port;    // Port of the current transfer.
	logic        done;        // Sticky transfer done.
	logic        claimed;     // Last answer claimed.
	logic        fw_seen;     // Sticky firmware reset seen.
	logic [7:0]  rdata;       // Last read byte.
	logic        apb_access;  // Access cycle before the answer.
	logic        apb_write;   // Write takes effect this edge.
	logic        start;       // Launch request this edge.
	logic        answer;      // Answer from the chosen port.
	logic        known;       // Address is mapped.

	assign apb_access = psel && penable && !pready;
	assign apb_write  = psel && penable && pready && pwrite;
	assign start      = apb_write && (paddr == APB_COMMAND) && pwdata[CMD_START]
		&& (state == DPC_IDLE);
	assign answer     = cmd_port ? port.m_ack : port.h_ack;
	assign known      = (paddr == APB_COMMAND) || (paddr == APB_ADDRESS)
		|| (paddr == APB_WDATA) || (paddr == APB_STATUS) || (paddr == APB_CONFIG);

	// Builds the status word.
	function automatic logic [31:0] status_word();
		logic [31:0] w;
		w = 32'h0000_0000;
		w[STS_BUSY]              = (state == DPC_WAIT);
		w[STS_DONE]              = done;
		w[STS_CLAIM]             = claimed;
		w[STS_CHECK]             = port.channel_check;
		w[STS_FWRST]             = fw_seen;
		w[STS_RDATA +: 8]        = rdata;
		return w;
	endfunction

	// ---------------------------------------------------------------
	// APB slave: one wait cycle, answer at the second access cycle.
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_access;
			pslverr <= apb_access && !known;
			prdata  <= 32'h0000_0000;
			if (apb_access && !pwrite) begin
				case (paddr)
					APB_ADDRESS: prdata <= port.h_addr;
					APB_WDATA:   prdata <= {24'h000000, port.h_wdata};
					APB_STATUS:  prdata <= status_word();
					APB_CONFIG:  prdata <= {25'h0, port.host_reset,
						port.slot_number, port.bus_kind};
					default:     prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Address, data and straps written by software.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port.h_addr      <= 32'h0000_0000;
			port.h_wdata     <= 8'h00;
			port.m_wdata     <= 8'h00;
			port.m_index     <= 5'h00;
			port.bus_kind    <= DPC_BUS_CHANNEL;
			port.slot_number <= 4'h0;
			port.host_reset  <= 1'b0;
		end else if (apb_write && (state == DPC_IDLE)) begin
			if (paddr == APB_ADDRESS) begin
				port.h_addr  <= pwdata;
				port.m_index <= pwdata[4:0];
			end
			if (paddr == APB_WDATA) begin
				port.h_wdata <= pwdata[7:0];
				port.m_wdata <= pwdata[7:0];
			end
			if (paddr == APB_CONFIG) begin
				port.bus_kind    <= dpc_bus_t'(pwdata[CFG_BUS +: 2]);
				port.slot_number <= pwdata[CFG_SLOT +: 4];
				port.host_reset  <= pwdata[CFG_HRST];
			end
		end
	end

	// Transfer machine: request held until the chosen port answers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state        <= DPC_IDLE;
			cmd_port     <= 1'b0;
			port.h_req   <= 1'b0;
			port.h_write <= 1'b0;
			port.h_setup <= 1'b0;
			port.m_req   <= 1'b0;
			port.m_write <= 1'b0;
		end else begin
			case (state)
				DPC_IDLE: begin
					if (start) begin
						state        <= DPC_WAIT;
						cmd_port     <= pwdata[CMD_PORT];
						port.h_req   <= !pwdata[CMD_PORT];
						port.m_req   <= pwdata[CMD_PORT];
						port.h_write <= pwdata[CMD_WRITE];
						port.m_write <= pwdata[CMD_WRITE];
						port.h_setup <= pwdata[CMD_SETUP];
					end
				end
				DPC_WAIT: begin
					if (answer) begin
						state      <= DPC_IDLE;
						port.h_req <= 1'b0;
						port.m_req <= 1'b0;
					end
				end
				default: state <= DPC_IDLE;
			endcase
		end
	end

	// Results and sticky flags; a new event wins over a clear.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			done    <= 1'b0;
			claimed <= 1'b0;
			fw_seen <= 1'b0;
			rdata   <= 8'h00;
		end else begin
			if (state == DPC_WAIT && answer) begin
				done    <= 1'b1;
				claimed <= cmd_port ? 1'b1 : port.h_claim;
				rdata   <= cmd_port ? port.m_rdata : port.h_rdata;
			end else if (apb_write && (paddr == APB_STATUS) && pwdata[STS_DONE]) begin
				done <= 1'b0;
			end
			if (port.fw_reset) begin
				fw_seen <= 1'b1;
			end else if (apb_write && (paddr == APB_STATUS) && pwdata[STS_FWRST]) begin
				fw_seen <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// file: core/dpc_regbank.sv
// Dual-ported configuration register bank, registers 0 to 5.
// Assumes sys_clk at 250 MHz, rst a synchronous power-up reset, and that each
// requester holds its request steady until it sees its one-cycle answer.
//
// How it works
// - Host and MPU reach registers by access letter.
// - Host reset pin hard-resets; reset bit firmware-resets.
// - Slot ID: MPU writes only, host reads only.
// - Firmware loads slot ID before setup.
// - Registers 0,1,2 survive firmware reset; hard reset spares 0,1 and clears reg2 bit 0 on a channel bus.
// - Register 2 read/write from both ports.
// - Channel card enable gates non-setup host access.
// - Channel/ISA: no decode until base written.
// - Channel decode: base against address 15..8.
// - ISA decode: base against address 9..5.
// - EISA register 3 is general storage.
// - EISA base fixed at slot-specific C80h.
// - Backplane decode in slot nibble space.
// - Hard reset clears reg4 bits 0-2; firmware bit 1.
// - EISA enable flag is storage only.
// - EISA channel check follows reg4 bit 1.
// - Writing reg4 bit 2 latches programmable reset.
// - Programmable reset spares regs 2,3,5 and port logic.
// - Reg4 bits 3-7 undefined, unused.
// - Register 5 cleared by hard reset, both ports.
`timescale 1ns/1ps
`default_nettype none

module dpc_regbank
	import dpc_pkg::*;
(
	input  wire logic sys_clk,  // System clock.
	input  wire logic rst,      // Synchronous power-up reset.
	dpc_if.dev        port      // Host and MPU ports.
);

	// ---------------------------------------------------------------
	// Storage.
	// ---------------------------------------------------------------
	logic [7:0] slot_id_low;               // Register 0.
	logic [7:0] slot_id_high;              // Register 1.
	logic [7:0] card_enable_config;        // Register 2.
	logic [7:0] io_base_address;           // Register 3.
	logic [1:0] reset_and_check_control;   // Register 4 bits 1..0.
	logic       reset_latch;               // Register 4 bit 2, the latched reset.
	logic [7:0] arbitration_config;        // Register 5.
	logic       base_written;              // Register 3 written since power-up.

	// ---------------------------------------------------------------
	// Port decode.
	// ---------------------------------------------------------------
	logic       host_go;     // Host request not yet answered.
	logic       mpu_go;      // MPU request not yet answered.
	logic       host_decode; // Host address hits this card.
	logic       host_claim;  // Host access will be claimed.
	logic [4:0] host_index;  // Register index from the host address.
	logic       mpu_serve;   // MPU served this cycle.
	logic       host_wr;     // Host write strobe this cycle.
	logic       mpu_wr;      // MPU write strobe this cycle.
	logic       hard_reset;  // Host reset pin.

	// Returns the readable value of a register, zero where nothing is kept.
	function automatic logic [7:0] read_reg(input logic [4:0] idx);
		logic [7:0] value;
		value = 8'h00;
		case (idx)
			REG_SLOT_ID_LOW:     value = slot_id_low;
			REG_SLOT_ID_HIGH:    value = slot_id_high;
			REG_CARD_ENABLE_CFG: value = card_enable_config;
			REG_IO_BASE_ADDRESS: value = io_base_address;
			// Bits 7..3 read as zero and hold nothing.
			REG_RESET_CHECK_CTL: value = {5'h00, reset_latch, reset_and_check_control};
			REG_ARBITRATION_CFG: value = arbitration_config;
			default:             value = 8'h00;
		endcase
		return value;
	endfunction
	// True when a write from the given port lands on the given register.
	function automatic logic hits(input logic strobe, input logic [4:0] idx,
		input logic [4:0] target);
		return strobe && (idx == target);
	endfunction
	assign hard_reset = port.host_reset; // Host pin is the hard reset.
	assign host_index = port.h_addr[4:0];
	assign host_go    = port.h_req && !port.h_ack;
	assign mpu_go     = port.m_req && !port.m_ack;
	// Decides whether the host address belongs to this card.
	always_comb begin
		host_decode = 1'b0;
		case (port.bus_kind)
			DPC_BUS_CHANNEL: begin
				// Compare base against bits 15..8, only once it is written.
				host_decode = base_written && (port.h_addr[15:8] == io_base_address)
					&& card_enable_config[BIT_CHANNEL_CARD_ENABLE];
			end
			DPC_BUS_ISA: begin
				// Compare base against bits 9..5, only once it is written.
				host_decode = base_written && (port.h_addr[9:5] == io_base_address[4:0]);
			end
			DPC_BUS_EISA: begin
				// Fixed base with the slot number as leading digit.
				host_decode = (port.h_addr[15:12] == port.slot_number)
					&& (port.h_addr[11:5] == EISA_BASE_UPPER);
			end
			DPC_BUS_BACKPLANE: begin
				// Slot nibble space with a 32-register index field.
				host_decode = (port.h_addr[31:28] == BACKPLANE_TOP)
					&& (port.h_addr[27:24] == port.slot_number)
					&& (port.h_addr[19:8] == 12'h000)
					&& (port.h_addr[7:5] == SLOT_WINDOW_UPPER);
			end
			default: host_decode = 1'b0;
		endcase
	end

	// Setup cycles are always answered, even with the card disabled.
	assign host_claim = port.h_setup || host_decode;
	// The MPU waits one cycle when the host hits the same register.
	assign mpu_serve = mpu_go && !(host_go && host_claim && (host_index == port.m_index));
	// Host may not write the slot ID registers.
	assign host_wr = host_go && host_claim && port.h_write && !hard_reset
		&& (host_index != REG_SLOT_ID_LOW) && (host_index != REG_SLOT_ID_HIGH);
	assign mpu_wr  = mpu_serve && port.m_write && !hard_reset;

	// ---------------------------------------------------------------
	// Port answers.
	// ---------------------------------------------------------------
	// Host answer: one-cycle acknowledge with the claim and read byte.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port.h_ack   <= 1'b0;
			port.h_claim <= 1'b0;
			port.h_rdata <= 8'h00;
		end else begin
			port.h_ack   <= host_go;
			port.h_claim <= host_go && host_claim;
			// Host reads every kept register, slot ID included.
			port.h_rdata <= (host_go && host_claim && !port.h_write)
				? read_reg(host_index) : 8'h00;
		end
	end

	// MPU answer: one-cycle acknowledge; slot ID reads return zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port.m_ack   <= 1'b0;
			port.m_rdata <= 8'h00;
		end else begin
			port.m_ack <= mpu_serve;
			if (mpu_serve && !port.m_write && (port.m_index != REG_SLOT_ID_LOW)
				&& (port.m_index != REG_SLOT_ID_HIGH)) begin
				port.m_rdata <= read_reg(port.m_index);
			end else begin
				port.m_rdata <= 8'h00;
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers 0 and 1.
	// ---------------------------------------------------------------
	// Slot ID bytes: MPU writes only, no reset but power-up.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slot_id_low  <= CFG_RESET_VALUE;
			slot_id_high <= CFG_RESET_VALUE;
		end else begin
			if (hits(mpu_wr, port.m_index, REG_SLOT_ID_LOW)) begin
				slot_id_low <= port.m_wdata;
			end
			if (hits(mpu_wr, port.m_index, REG_SLOT_ID_HIGH)) begin
				slot_id_high <= port.m_wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers 2 and 3.
	// ---------------------------------------------------------------
	// Register 2: both ports; only the channel enable bit sees hard reset.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			card_enable_config <= CFG_RESET_VALUE;
		end else if (hard_reset) begin
			if (port.bus_kind == DPC_BUS_CHANNEL) begin
				card_enable_config[BIT_CHANNEL_CARD_ENABLE] <= 1'b0;
			end
		end else if (hits(host_wr, host_index, REG_CARD_ENABLE_CFG)) begin
			card_enable_config <= port.h_wdata;
		end else if (hits(mpu_wr, port.m_index, REG_CARD_ENABLE_CFG)) begin
			card_enable_config <= port.m_wdata;
		end
	end

	// Register 3: base address or general storage; firmware reset spares it.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			io_base_address <= CFG_RESET_VALUE;
			base_written    <= 1'b0;
		end else if (hits(host_wr, host_index, REG_IO_BASE_ADDRESS)) begin
			io_base_address <= port.h_wdata;
			base_written    <= 1'b1;
		end else if (hits(mpu_wr, port.m_index, REG_IO_BASE_ADDRESS)) begin
			io_base_address <= port.m_wdata;
			base_written    <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Register 4 and the programmable reset.
	// ---------------------------------------------------------------
	// Enable flag and check bit: hard reset clears both, firmware bit 1.
	always_ff @(posedge sys_clk) begin
		if (rst || hard_reset) begin
			reset_and_check_control <= 2'b00;
		end else if (reset_latch) begin
			reset_and_check_control[BIT_EISA_CHANNEL_CHECK_DRIVE] <= 1'b0;
		end else if (hits(host_wr, host_index, REG_RESET_CHECK_CTL)) begin
			// The enable flag is stored only and steers nothing.
			reset_and_check_control <= port.h_wdata[1:0];
		end else if (hits(mpu_wr, port.m_index, REG_RESET_CHECK_CTL)) begin
			reset_and_check_control <= port.m_wdata[1:0];
		end
	end

	// Writing one to bit 2 latches a one-cycle firmware reset.
	always_ff @(posedge sys_clk) begin
		if (rst || hard_reset) begin
			reset_latch <= 1'b0;
		end else if (reset_latch) begin
			reset_latch <= 1'b0;
		end else if (hits(host_wr, host_index, REG_RESET_CHECK_CTL)) begin
			reset_latch <= port.h_wdata[BIT_PROGRAMMABLE_RESET];
		end else if (hits(mpu_wr, port.m_index, REG_RESET_CHECK_CTL)) begin
			reset_latch <= port.m_wdata[BIT_PROGRAMMABLE_RESET];
		end
	end

	// Firmware reset pulse to the chip, one cycle after the latch sets.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port.fw_reset <= 1'b0;
		end else begin
			port.fw_reset <= reset_latch;
		end
	end

	// Channel check drive follows bit 1 on an EISA host only.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port.channel_check <= 1'b0;
		end else begin
			port.channel_check <= (port.bus_kind == DPC_BUS_EISA)
				&& reset_and_check_control[BIT_EISA_CHANNEL_CHECK_DRIVE];
		end
	end

	// ---------------------------------------------------------------
	// Register 5.
	// ---------------------------------------------------------------
	// Cleared by hard reset, untouched by firmware reset, both ports.
	always_ff @(posedge sys_clk) begin
		if (rst || hard_reset) begin
			arbitration_config <= CFG_RESET_VALUE;
		end else if (hits(host_wr, host_index, REG_ARBITRATION_CFG)) begin
			arbitration_config <= port.h_wdata;
		end else if (hits(mpu_wr, port.m_index, REG_ARBITRATION_CFG)) begin
			arbitration_config <= port.m_wdata;
		end
	end

endmodule

`default_nettype wire

// file: shared/dpc_if.sv
// Interface joining the register bank to the party that drives its ports.
// Assumes one clock, sys_clk, shared by both ends.
`timescale 1ns/1ps
`default_nettype none

interface dpc_if
	import dpc_pkg::*;
();
	logic        host_reset;   // Host reset pin, active high level.
	dpc_bus_t    bus_kind;     // Host bus kind strap.
	logic [3:0]  slot_number;  // Slot number strap.
	logic        h_req;        // Host request, held until h_ack.
	logic        h_write;      // Host direction, 1 write.
	logic        h_setup;      // Host setup cycle.
	logic [31:0] h_addr;       // Host address.
	logic [7:0]  h_wdata;      // Host write byte.
	logic        h_ack;        // Host answer pulse.
	logic        h_claim;      // Device claimed the host access.
	logic [7:0]  h_rdata;      // Host read byte.
	logic        m_req;        // MPU request, held until m_ack.
	logic        m_write;      // MPU direction, 1 write.
	logic [4:0]  m_index;      // MPU register index.
	logic [7:0]  m_wdata;      // MPU write byte.
	logic        m_ack;        // MPU answer pulse.
	logic [7:0]  m_rdata;      // MPU read byte.
	logic        channel_check; // Channel check drive to the host bus.
	logic        fw_reset;     // Firmware reset pulse to the chip.

	// The register bank end.
	modport dev (
		input  host_reset, bus_kind, slot_number,
		input  h_req, h_write, h_setup, h_addr, h_wdata,
		output h_ack, h_claim, h_rdata,
		input  m_req, m_write, m_index, m_wdata,
		output m_ack, m_rdata, channel_check, fw_reset
	);

	// The controller end that plays host and MPU.
	modport ctl (
		output host_reset, bus_kind, slot_number,
		output h_req, h_write, h_setup, h_addr, h_wdata,
		input  h_ack, h_claim, h_rdata,
		output m_req, m_write, m_index, m_wdata,
		input  m_ack, m_rdata, channel_check, fw_reset
	);
endinterface

`default_nettype wire

// file: shared/dpc_pkg.sv
// Package for the dual-ported configuration register bank.
// Holds register offsets, field positions, bus kinds, decode patterns and
// the map of the controller's own APB registers; both ends import it.
`default_nettype none

package dpc_pkg;

	// ---------------------------------------------------------------
	// Configuration register indexes (5-bit register map).
	// ---------------------------------------------------------------
	localparam logic [4:0] REG_SLOT_ID_LOW     = 5'h00; // Slot ID byte 0.
	localparam logic [4:0] REG_SLOT_ID_HIGH    = 5'h01; // Slot ID byte 1.
	localparam logic [4:0] REG_CARD_ENABLE_CFG = 5'h02; // Card enable config.
	localparam logic [4:0] REG_IO_BASE_ADDRESS = 5'h03; // I/O base address.
	localparam logic [4:0] REG_RESET_CHECK_CTL = 5'h04; // Reset and check control.
	localparam logic [4:0] REG_ARBITRATION_CFG = 5'h05; // Arbitration config.

	// ---------------------------------------------------------------
	// Field positions and reset values.
	// ---------------------------------------------------------------
	localparam int         BIT_CHANNEL_CARD_ENABLE      = 0; // Register 2 bit 0.
	localparam int         BIT_EISA_CARD_ENABLE_FLAG    = 0; // Register 4 bit 0.
	localparam int         BIT_EISA_CHANNEL_CHECK_DRIVE = 1; // Register 4 bit 1.
	localparam int         BIT_PROGRAMMABLE_RESET       = 2; // Register 4 bit 2.
	localparam logic [7:0] CFG_RESET_VALUE              = 8'h00; // Value after reset.

	// ---------------------------------------------------------------
	// Host bus kinds and address decode patterns.
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		DPC_BUS_CHANNEL   = 2'h0, // Slot-configured channel bus.
		DPC_BUS_ISA       = 2'h1, // ISA bus.
		DPC_BUS_EISA      = 2'h2, // EISA bus.
		DPC_BUS_BACKPLANE = 2'h3  // Slot-addressed backplane bus.
	} dpc_bus_t;

	localparam logic [6:0] EISA_BASE_UPPER    = 7'h64; // Bits 11..5 of C80h.
	localparam logic [3:0] BACKPLANE_TOP      = 4'hf;  // Leading nibble F.
	localparam logic [2:0] SLOT_WINDOW_UPPER  = 3'h0;  // Index bits 7..5 zero.

	// ---------------------------------------------------------------
	// Controller APB register map (byte addresses).
	// ---------------------------------------------------------------
	localparam logic [7:0] APB_COMMAND = 8'h00; // Start, port, write, setup.
	localparam logic [7:0] APB_ADDRESS = 8'h04; // Host address or MPU index.
	localparam logic [7:0] APB_WDATA   = 8'h08; // Write byte.
	localparam logic [7:0] APB_STATUS  = 8'h0c; // Busy, done, claim, data.
	localparam logic [7:0] APB_CONFIG  = 8'h10; // Bus kind, slot, hard reset.

	localparam int CMD_START = 0; // Write 1 to launch a transfer.
	localparam int CMD_PORT  = 1; // 0 host port, 1 MPU port.
	localparam int CMD_WRITE = 2; // 1 write, 0 read.
	localparam int CMD_SETUP = 3; // Host setup cycle.
	localparam int STS_BUSY  = 0; // Transfer in flight.
	localparam int STS_DONE  = 1; // Sticky; write 1 to clear.
	localparam int STS_CLAIM = 2; // Device claimed the access.
	localparam int STS_CHECK = 3; // Channel check drive seen.
	localparam int STS_FWRST = 4; // Firmware reset seen; write 1 to clear.
	localparam int STS_RDATA = 8; // Read byte at bits 15..8.
	localparam int CFG_BUS   = 0; // Bus kind at bits 1..0.
	localparam int CFG_SLOT  = 2; // Slot number at bits 5..2.
	localparam int CFG_HRST  = 6; // Hard reset pin level.

endpackage

`default_nettype wire

// file: tb/dpc_chk.sv
// Checker that watches the bank's host and MPU ports.
// Assumes it is wired to the shared interface signals by name.
`timescale 1ns/1ps
`default_nettype none
module dpc_chk
	import dpc_pkg::*;
(
	input wire logic        sys_clk, rst, host_reset, h_req, h_setup, h_ack, h_claim,
	input wire logic        m_req, m_write, m_ack, channel_check, fw_reset,
	input wire dpc_bus_t    bus_kind,
	input wire logic [3:0]  slot_number,
	input wire logic [31:0] h_addr,
	input wire logic [4:0]  m_index,
	input wire logic [7:0]  m_rdata
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_hack; h_req && !h_ack |=> h_ack; endproperty
	a_hack: assert property (p_hack) else $error("host ack late");
	property p_mack; m_req && !m_ack |-> ##[1:2] m_ack; endproperty
	a_mack: assert property (p_mack) else $error("mpu ack late");
	property p_slot; m_ack && !m_write && m_index < 5'h02 |-> m_rdata == 8'h00; endproperty
	a_slot: assert property (p_slot) else $error("slot id seen by mpu");
	property p_eisa; h_ack && h_claim && !h_setup && bus_kind == DPC_BUS_EISA
		|-> h_addr[15:5] == {slot_number, EISA_BASE_UPPER}; endproperty
	a_eisa: assert property (p_eisa) else $error("eisa decode wrong");
	property p_fw; fw_reset |=> !fw_reset; endproperty
	a_fw: assert property (p_fw) else $error("firmware reset too long");
	property p_hrst; host_reset [*2] |=> !channel_check; endproperty
	a_hrst: assert property (p_hrst) else $error("check kept in reset");
	property p_chk; channel_check |-> $past(bus_kind) == DPC_BUS_EISA; endproperty
	a_chk: assert property (p_chk) else $error("check off eisa");
	property p_claim; h_claim |-> h_ack; endproperty
	a_claim: assert property (p_claim) else $error("claim without ack");
endmodule
`default_nettype wire

// file: tb/test_dual_port_config_registers.sv
// Testbench: APB drives the controller, which drives the bank.
// Assumes the design files, the interface and the checker.
`timescale 1ns/1ps
`default_nettype none
module test_dual_port_config_registers
	import dpc_pkg::*;
;
	logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, sts;
	int          errors = 0, checked = 0;
	dpc_if bus ();
	dpc_regbank i_dpc_regbank (.sys_clk(sys_clk), .rst(rst), .port(bus.dev));
	dpc_ctl i_dpc_ctl (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port(bus.ctl));
	dpc_chk i_dpc_chk (.sys_clk(sys_clk), .rst(rst), .host_reset(bus.host_reset),
		.bus_kind(bus.bus_kind), .slot_number(bus.slot_number), .h_req(bus.h_req),
		.h_setup(bus.h_setup), .h_addr(bus.h_addr), .h_ack(bus.h_ack), .h_claim(bus.h_claim),
		.m_req(bus.m_req), .m_write(bus.m_write), .m_index(bus.m_index), .m_ack(bus.m_ack),
		.m_rdata(bus.m_rdata), .channel_check(bus.channel_check), .fw_reset(bus.fw_reset));
	always #2 sys_clk = ~sys_clk;
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Compares a seen byte with the expected one.
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One APB transfer; a read leaves its data in sts.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (!w) sts = prdata;
		psel <= 1'b0; penable <= 1'b0;
		if (n >= 20) begin errors++; wrap_up(); end
	endtask
	// Launches one bank transfer and waits for the done flag.
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [7:0] d);
		int n;
		n = 0;
		apb(1'b1, APB_ADDRESS, a);
		apb(1'b1, APB_WDATA, {24'h0, d});
		apb(1'b1, APB_COMMAND, {28'h0, cmd});
		do begin
			apb(1'b0, APB_STATUS, 32'h0);
			n++;
		end while (sts[STS_DONE] !== 1'b1 && n < 20);
		if (n >= 20) begin errors++; wrap_up(); end
		apb(1'b1, APB_STATUS, 32'h02);
	endtask
	// Slot ID bytes: MPU writes, host reads only.
	task automatic t_slot;
		xfer(4'h7, 32'h0, 8'ha5);
		xfer(4'h9, 32'h0, 8'h00);
		chk(sts[15:8], 8'ha5);
		xfer(4'hd, 32'h0, 8'h3c);
		xfer(4'h9, 32'h0, 8'h00);
		chk(sts[15:8], 8'ha5);
		xfer(4'h3, 32'h0, 8'h00);
		chk(sts[15:8], 8'h00);
		apb(1'b1, 8'h20, 32'h0);
		chk({7'h0, pslverr}, 8'h01);
		$display("slot test done");
	endtask
	// Firmware reset spares registers 3 and 5; the reset pin clears 5 and spares the slot ID.
	task automatic t_rst;
		xfer(4'h7, 32'h5, 8'h3c);
		xfer(4'h7, 32'h3, 8'h77);
		xfer(4'h7, 32'h4, 8'h04);
		apb(1'b0, APB_STATUS, 32'h0);
		chk({7'h0, sts[STS_FWRST]}, 8'h01);
		apb(1'b1, APB_STATUS, 32'h10);
		xfer(4'h3, 32'h5, 8'h00);
		chk(sts[15:8], 8'h3c);
		xfer(4'h3, 32'h3, 8'h00);
		chk(sts[15:8], 8'h77);
		apb(1'b1, APB_CONFIG, 32'h40);
		apb(1'b1, APB_CONFIG, 32'h0);
		xfer(4'h3, 32'h5, 8'h00);
		chk(sts[15:8], 8'h00);
		xfer(4'h9, 32'h0, 8'h00);
		chk(sts[15:8], 8'ha5);
		$display("reset test done");
	endtask
	// EISA: fixed slot decode and the channel check drive.
	task automatic t_eisa;
		apb(1'b1, APB_CONFIG, 32'h0e);
		xfer(4'h5, 32'h3c84, 8'h02);
		chk({7'h0, sts[STS_CLAIM]}, 8'h01);
		apb(1'b0, APB_STATUS, 32'h0);
		chk({7'h0, sts[STS_CHECK]}, 8'h01);
		xfer(4'h1, 32'h4c84, 8'h00);
		chk({7'h0, sts[STS_CLAIM]}, 8'h00);
		apb(1'b1, APB_CONFIG, 32'h4e);
		apb(1'b0, APB_STATUS, 32'h0);
		chk({7'h0, sts[STS_CHECK]}, 8'h00);
		apb(1'b1, APB_CONFIG, 32'h0);
		$display("eisa test done");
	endtask
	// Channel, ISA and backplane decode of the base and slot space.
	task automatic t_dec;
		xfer(4'h1, 32'h7703, 8'h00);
		chk({7'h0, sts[STS_CLAIM]}, 8'h00);
		xfer(4'h7, 32'h2, 8'h01);
		xfer(4'h1, 32'h7703, 8'h00);
		chk(sts[15:8], 8'h77);
		apb(1'b1, APB_CONFIG, 32'h01);
		xfer(4'h1, 32'h02e3, 8'h00);
		chk(sts[15:8], 8'h77);
		apb(1'b1, APB_CONFIG, 32'h17);
		xfer(4'h1, 32'hf5000003, 8'h00);
		chk(sts[15:8], 8'h77);
		xfer(4'h1, 32'hf6000003, 8'h00);
		chk({7'h0, sts[STS_CLAIM]}, 8'h00);
		apb(1'b1, APB_CONFIG, 32'h0);
		$display("decode test done");
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_slot();
		t_rst();
		t_dec();
		t_eisa();
		wrap_up();
	end
endmodule
`default_nettype wire
